// *** kei_key_edge_irq.v ***
// Key interrupt unit: six key pins, level request or, with optional flags, edge detect, one request
// Assumes a single-cycle byte register port from the CPU at i_clock
`timescale 1ns/1ps
`default_nettype none
`include "kei_defines.vh"

module kei_key_edge_irq #(
    parameter NUM_KEYS = 6
) (
    // Clock and reset
    input  wire                   i_clock,
    input  wire                   i_rst_n,
    // Register port
    input  wire [`KEI_ADDR_W-1:0] i_addr,
    input  wire                   i_wr,
    input  wire                   i_rd,
    input  wire [7:0]             i_wdata,
    output reg  [7:0]             o_rdata,
    // Key pins
    input  wire [NUM_KEYS-1:0]    i_key_input_pins,
    // Port direction to pad logic
    output reg  [7:0]             o_port0_direction,
    output reg  [7:0]             o_port4_direction,
    // Combined request
    output reg                    o_keypad_irq
);

    // ****************************************
    // Registers
    // ****************************************
    reg                key_control_flag;
    reg                key_control_edge;
    reg [NUM_KEYS-1:0] key_channel_enable;
    reg [NUM_KEYS-1:0] key_event_flags;
    reg [NUM_KEYS-1:0] armed;

    wire [NUM_KEYS-1:0] pin_sync;
    wire [NUM_KEYS-1:0] active;
    wire [NUM_KEYS-1:0] detect;
    wire [NUM_KEYS-1:0] first_detect;
    wire                comb_level;
    wire                wr_ctrl;
    wire                wr_enable;
    wire                wr_flags;
    wire                wr_port0;
    wire                wr_port4;
    reg  [NUM_KEYS-1:0] next_flags;
    reg  [NUM_KEYS-1:0] next_armed;
    reg                 next_irq;
    reg  [7:0]          next_rdata;

    kei_pin_sync #(
        .WIDTH (NUM_KEYS)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async (i_key_input_pins),
        .o_sync  (pin_sync)
    );

    // Active level per channel, masked by enable
    assign active = (key_control_edge ? pin_sync : ~pin_sync)
                    & key_channel_enable;
    assign comb_level = |active;

    // ****************************************
    // Address decode
    // ****************************************
    assign wr_ctrl   = i_wr && (i_addr == `KEI_ADDR_KEY_CTRL);
    assign wr_enable = i_wr && (i_addr == `KEI_ADDR_CH_ENABLE);
    assign wr_flags  = i_wr && (i_addr == `KEI_ADDR_EV_FLAGS);
    assign wr_port0  = i_wr && (i_addr == `KEI_ADDR_PORT0_DIR);
    assign wr_port4  = i_wr && (i_addr == `KEI_ADDR_PORT4_DIR);

    // ****************************************
    // Edge detection per channel
    // ****************************************
    // A channel is armed once it leaves the active level; enabling while
    // already active counts as an edge because armed starts set.
    genvar g;
    generate
        for (g = 0; g < NUM_KEYS; g = g + 1) begin : g_chan
            assign detect[g] = active[g] & armed[g];
        end
    endgenerate

    assign first_detect = lowest_one(detect);

    // ****************************************
    // Flag update
    // ****************************************
    always @* begin
        next_flags = key_event_flags;
        next_armed = {NUM_KEYS{1'b1}};
        if (key_control_flag) begin
            if (wr_flags) begin
                next_flags = key_event_flags & i_wdata[NUM_KEYS-1:0];
            end
            // One flag held at a time; other edges wait for the clear
            if (next_flags == {NUM_KEYS{1'b0}}) begin
                next_flags = first_detect;
            end
            // Pending edges stay armed until flagged
            next_armed = ~active | (detect & ~next_flags);
        end else begin
            next_flags = {NUM_KEYS{1'b0}};
        end
    end

    // Lowest set bit of a vector
    function [NUM_KEYS-1:0] lowest_one;
        input [NUM_KEYS-1:0] v;
        begin
            lowest_one = v & (~v + {{(NUM_KEYS-1){1'b0}}, 1'b1});
        end
    endfunction

    // ****************************************
    // Request source
    // ****************************************
    always @* begin
        if (key_control_flag) begin
            next_irq = |next_flags;
        end else begin
            next_irq = comb_level;
        end
    end

    // ****************************************
    // Control and enable registers
    // ****************************************
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            key_control_flag   <= 1'b0;
            key_control_edge   <= 1'b0;
            key_channel_enable <= {NUM_KEYS{1'b0}};
        end else begin
            if (wr_ctrl) begin
                key_control_flag <= i_wdata[`KEI_CTRL_FLAG_BIT];
                key_control_edge <= i_wdata[`KEI_CTRL_EDGE_BIT];
            end
            if (wr_enable) begin
                key_channel_enable <= i_wdata[NUM_KEYS-1:0];
            end
        end
    end

    // ****************************************
    // Port direction registers
    // ****************************************
    // Unimplemented bits are forced to input
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_port0_direction <= `KEI_RST_DIR;
            o_port4_direction <= `KEI_RST_DIR;
        end else begin
            if (wr_port0) begin
                o_port0_direction <= i_wdata | ~`KEI_PORT0_DIR_MASK;
            end
            if (wr_port4) begin
                o_port4_direction <= i_wdata | ~`KEI_PORT4_DIR_MASK;
            end
        end
    end

    // ****************************************
    // Flags, arming and request
    // ****************************************
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            key_event_flags <= {NUM_KEYS{1'b0}};
            armed           <= {NUM_KEYS{1'b1}};
            o_keypad_irq    <= 1'b0;
        end else begin
            key_event_flags <= next_flags;
            armed           <= next_armed;
            o_keypad_irq    <= next_irq;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always @* begin
        next_rdata = 8'h00;
        case (i_addr)
            `KEI_ADDR_KEY_CTRL:
                next_rdata = {key_control_flag, 6'h00, key_control_edge};
            `KEI_ADDR_CH_ENABLE:
                next_rdata = {{(8-NUM_KEYS){1'b0}}, key_channel_enable};
            `KEI_ADDR_EV_FLAGS:
                next_rdata = {{(8-NUM_KEYS){1'b0}}, key_event_flags};
            `KEI_ADDR_PORT0_DIR: next_rdata = o_port0_direction;
            `KEI_ADDR_PORT4_DIR: next_rdata = o_port4_direction;
            default:             next_rdata = 8'h00;
        endcase
    end

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// *** kei_defines.vh ***
// Register map, field positions and reset values of the key interrupt unit
// Included by the unit, its checker and the bench, not by the synchroniser; definitions only
`ifndef KEI_DEFINES_VH
`define KEI_DEFINES_VH

// ****************************************
// Register addresses (20-bit space)
// ****************************************
`define KEI_ADDR_W          20
`define KEI_ADDR_PORT0_DIR  20'hfff20
`define KEI_ADDR_KEY_CTRL   20'hfff34
`define KEI_ADDR_CH_ENABLE  20'hfff37
`define KEI_ADDR_EV_FLAGS   20'hfff35
`define KEI_ADDR_PORT4_DIR  20'hfff24

// ****************************************
// Fields and reset values
// ****************************************
`define KEI_CTRL_FLAG_BIT   7
`define KEI_CTRL_EDGE_BIT   0
`define KEI_RST_CTRL        8'h00
`define KEI_RST_ENABLE      8'h00
`define KEI_RST_FLAGS       8'h00
`define KEI_RST_DIR         8'hff
`define KEI_PORT0_DIR_MASK  8'h1e
`define KEI_PORT4_DIR_MASK  8'h01

`endif

// *** kei_pin_sync.v ***
// Two-stage synchroniser for the key input pins
// Assumes pins are asynchronous to i_clock
`timescale 1ns/1ps
`default_nettype none

module kei_pin_sync #(
    parameter WIDTH = 6
) (
    // Clock and reset
    input  wire             i_clock,
    input  wire             i_rst_n,
    // Pins in, synchronised levels out
    input  wire [WIDTH-1:0] i_async,
    output reg  [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] stage1;

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage1 <= {WIDTH{1'b1}};
            o_sync <= {WIDTH{1'b1}};
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end

endmodule

`default_nettype wire

// *** kei_key_edge_irq_assertions.sv ***
// Port checker for the key interrupt unit
// Assumes kei_defines.vh on the include path; bound below
`timescale 1ns/1ps
`default_nettype none
`include "kei_defines.vh"
module kei_key_edge_irq_chk (
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [19:0] i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic [7:0]  o_rdata,
    input wire logic [7:0]  o_port0_direction,
    input wire logic [7:0]  o_port4_direction,
    input wire logic        o_keypad_irq
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence p0_wr;
        i_wr && i_addr == `KEI_ADDR_PORT0_DIR;
    endsequence
    sequence p4_wr;
        i_wr && i_addr == `KEI_ADDR_PORT4_DIR;
    endsequence
    dir_reset_a: assert property ($rose(i_rst_n) |->
        (o_port0_direction & o_port4_direction) == 8'hff)
        else $error("direction not ff after reset");
    dir_fixed_a: assert property ((o_port0_direction | 8'h1e) == 8'hff
        && (o_port4_direction | 8'h01) == 8'hff)
        else $error("unimplemented direction bit low");
    p0_write_a: assert property (p0_wr |=>
        o_port0_direction == ($past(i_wdata) | 8'he1))
        else $error("port0 direction write wrong");
    p4_write_a: assert property (p4_wr |=>
        o_port4_direction == ($past(i_wdata) | 8'hfe))
        else $error("port4 direction write wrong");
    dir_hold_a: assert property (!(i_wr && i_addr[19:4] == 16'hfff2) |=>
        $stable(o_port0_direction) && $stable(o_port4_direction))
        else $error("direction changed without write");
    ctrl_zero_a: assert property (i_rd && i_addr == `KEI_ADDR_KEY_CTRL
        |=> o_rdata[6:1] == 6'h00) else $error("control bits 6..1 not 0");
    unmapped_rd_a: assert property (i_rd && i_addr == 20'h00000
        |=> o_rdata == 8'h00) else $error("unmapped read not 0");
    rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata))
        else $error("read data changed without read");
    irq_reset_a: assert property ($rose(i_rst_n) |-> !o_keypad_irq)
        else $error("request high after reset");
    en_upper_a: assert property (i_rd && i_addr == `KEI_ADDR_CH_ENABLE
        |=> o_rdata[7:6] == 2'b00) else $error("enable bits 7..6 not 0");
endmodule
bind kei_key_edge_irq kei_key_edge_irq_chk u_chk (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_port0_direction(o_port0_direction),
    .o_port4_direction(o_port4_direction),
    .o_keypad_irq(o_keypad_irq));
`default_nettype wire

// *** kei_keypad_model.sv ***
// Keypad on the key pins: pull-ups, a pressed key pulls its pin low
// Assumes the bench drives the press vector
`timescale 1ns/1ps
`default_nettype none
module kei_keypad_model (
    input  wire logic [5:0] i_press,
    output var  logic [5:0] o_pins
);
    always_comb o_pins = ~i_press;
endmodule
`default_nettype wire

// *** tb_key_edge_interrupt.sv ***
// Self-checking bench: registers, key pins, combined request
// Assumes design, keypad model and kei_defines.vh compiled first
`timescale 1ns/1ps
`default_nettype none
`include "kei_defines.vh"
module tb_key_edge_interrupt;
    localparam [19:0] CT = `KEI_ADDR_KEY_CTRL;
    localparam [19:0] EN = `KEI_ADDR_CH_ENABLE;
    localparam [19:0] FL = `KEI_ADDR_EV_FLAGS;
    logic        clk = 0, rst_n = 0, wr = 0, rd = 0, rd_p = 0, ci = 0, irq;
    logic        ci_p = 0;
    logic [19:0] addr = 0;
    logic [7:0]  wd = 0, rdata, d0, d4, qr[$];
    logic [5:0]  press = 0, pins;
    logic        qi[$];
    logic [31:0] lf = 32'h48467e80;
    int          error_cnt = 0, n_tests = 0, t = 0;
    kei_key_edge_irq dut (.i_clock(clk), .i_rst_n(rst_n), .i_addr(addr),
        .i_wr(wr), .i_rd(rd), .i_wdata(wd), .o_rdata(rdata),
        .i_key_input_pins(pins), .o_port0_direction(d0),
        .o_port4_direction(d4), .o_keypad_irq(irq));
    kei_keypad_model kp (.i_press(press), .o_pins(pins));
    initial forever #25 clk = ~clk;
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic [7:0] s, e, input string nm);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wrt(input logic [19:0] a, input logic [7:0] d);
        @(negedge clk) {addr, wd, wr} = {a, d, 1'b1};
        @(negedge clk) wr = 0;
    endtask
    task automatic rdx(input logic [19:0] a, input logic [7:0] e);
        @(negedge clk) {addr, rd} = {a, 1'b1};
        qr.push_back(e);
        @(negedge clk) rd = 0;
    endtask
    task automatic irq_is(input logic e);
        @(negedge clk) qi.push_back(e);
        ci = 1;
        @(negedge clk) ci = 0;
    endtask
    task automatic key(input logic [5:0] p);
        press = p;
        repeat (5) @(negedge clk);
    endtask
    task automatic done();
        t++;
        $display("test %0d finished", t);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) rd_p <= rd;
    always @(negedge clk) if (rd_p) chk(rdata, qr.pop_front(), "rdata");
    always @(posedge clk) ci_p <= ci;
    always @(negedge clk)
        if (ci_p) chk({7'h0, irq}, {7'h0, qi.pop_front()}, "irq");
    initial begin
        #(3000 * 50);
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        rdx(CT, 8'h00);
        rdx(EN, 8'h00);
        rdx(`KEI_ADDR_PORT0_DIR, 8'hff);
        rdx(`KEI_ADDR_PORT4_DIR, 8'hff);
        rdx(20'h00000, 8'h00);
        done();
        repeat (4) begin
            lf = lfsr_next(lf);
            wrt(`KEI_ADDR_PORT0_DIR, lf[7:0]);
            rdx(`KEI_ADDR_PORT0_DIR, lf[7:0] | 8'he1);
            wrt(`KEI_ADDR_PORT4_DIR, lf[15:8]);
            rdx(`KEI_ADDR_PORT4_DIR, lf[15:8] | 8'hfe);
        end
        wrt(`KEI_ADDR_PORT0_DIR, 8'hff);
        wrt(`KEI_ADDR_PORT4_DIR, 8'hff);
        wrt(CT, 8'hff);
        rdx(CT, 8'h81);
        done();
        wrt(CT, 8'h00);
        wrt(EN, 8'h3e);
        key(6'h01); irq_is(0);
        key(6'h03); irq_is(1);
        key(6'h22); irq_is(1);
        key(6'h20); irq_is(1);
        key(6'h00); irq_is(0);
        wrt(CT, 8'h01);
        key(6'h00); irq_is(1);
        key(6'h3f); irq_is(0);
        done();
        wrt(CT, 8'h00);
        key(6'h00);
        wrt(CT, 8'h80);
        wrt(EN, 8'h3f);
        rdx(FL, 8'h00);
        key(6'h01); irq_is(1);
        rdx(FL, 8'h01);
        key(6'h03); rdx(FL, 8'h01);
        wrt(FL, 8'hfe); rdx(FL, 8'h02);
        irq_is(1);
        wrt(FL, 8'hff); rdx(FL, 8'h02);
        key(6'h00); irq_is(1);
        wrt(FL, 8'hfd); rdx(FL, 8'h00);
        irq_is(0);
        wrt(EN, 8'h00);
        key(6'h04); wrt(EN, 8'h04);
        key(6'h04); rdx(FL, 8'h04);
        wrt(FL, 8'hfb); key(6'h04); irq_is(0);
        done();
        rst_n = 0;
        @(negedge clk) rst_n = 1;
        rdx(CT, 8'h00);
        rdx(EN, 8'h00);
        irq_is(0);
        done();
        conclude();
    end
endmodule
`default_nettype wire
